/* File: logic/bus_matcher_pkg.sv */
// Constants shared by the duplex bus matcher and its cycle hold register.
// Assumes one 40 MHz clock and a synchronous active-high reset.
package bus_matcher_pkg;

  // ********************************************************************
  // Widths and reset values
  // ********************************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int MCR_W = 32;
  localparam logic [31:0] MCR_RESET = 32'h0000_0000;
  localparam logic [31:0] HOLD_RESET = 32'h0000_0000;

  // Phases of the outgoing match bus: address word first, then data word.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b11
  } match_phase_t;

endpackage

/* File: logic/cycle_hold.sv */
// Cycle hold register: a word pair with a lock that only a release or reset frees.
// Assumes the capture strobe and release pulse come from the same clock.
module cycle_hold
  import bus_matcher_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic capture,
  input wire logic release_lock,
  input wire logic [W-1:0] addr_in,
  input wire logic [W-1:0] data_in,
  output logic [W-1:0] addr_q,
  output logic [W-1:0] data_q,
  output logic locked
);

  // ********************************************************************
  // Capture and lock
  // ********************************************************************

  // Capture only while unlocked, so the first faulty cycle is kept for diagnosis.
  wire logic take = capture && !locked;

  // Set wins over release so a fault in the release cycle is not lost.
  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_q <= W'(HOLD_RESET);
      data_q <= W'(HOLD_RESET);
      locked <= 1'b0;
    end else begin
      if (take) begin
        addr_q <= addr_in;
        data_q <= data_in;
      end
      if (capture) begin
        locked <= 1'b1;
      end else if (release_lock) begin
        locked <= 1'b0;
      end
    end
  end

endmodule // cycle_hold

/* File: logic/bus_matcher.sv */
// Duplex bus matcher: compares local cycles with the mate's, sends local
// cycles to the mate, copies the mate's data in update mode, and keeps
// the mate communication register.
// Assumes bus strobes and mate inputs arrive from outside the clock domain.
//
// What this block does
// - Compare each local cycle with mate's cycle.
// - Send address then data on outgoing match bus.
// - Update mode steers incoming match bus to data.
// - Lock hold register after fault until released.
// - 32-bit register written locally, mate reads gated.
module bus_matcher
  import bus_matcher_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic cycle_strobe,
  input wire logic cycle_read,
  input wire logic [ADDR_W-1:0] local_addr,
  input wire logic [DATA_W-1:0] local_data,
  input wire logic mate_strobe,
  input wire logic [ADDR_W-1:0] mate_addr,
  input wire logic [DATA_W-1:0] mate_data,
  input wire logic [DATA_W-1:0] match_in,
  input wire logic update_req,
  input wire logic mcr_write,
  input wire logic mcr_to_measurement_bus,
  input wire logic clear_error,
  input wire logic release_lock,
  output logic [DATA_W-1:0] match_out,
  output logic match_out_valid,
  output logic match_out_is_data,
  output logic [DATA_W-1:0] update_data,
  output logic update_data_oe,
  output logic [MCR_W-1:0] measurement_bus,
  output logic measurement_bus_oe,
  output logic mismatch_pulse,
  output logic mismatch_error,
  output logic [ADDR_W-1:0] hold_addr,
  output logic [DATA_W-1:0] hold_data,
  output logic hold_locked
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************

  // Bus strobes and mode levels are two-flop synchronised; the first stage feeds only the second.
  localparam int SYNC_N = 5;
  localparam int IX_LOC = 4;
  localparam int IX_MATE = 3;
  localparam int IX_UPD = 2;
  localparam int IX_RD = 1;
  localparam int IX_SEL = 0;

  // Raw pin levels gathered into one vector so every bit gets the same treatment.
  logic [SYNC_N-1:0] raw_lvl;
  assign raw_lvl = {cycle_strobe, mate_strobe, update_req, cycle_read, mcr_to_measurement_bus};

  // One two-stage synchroniser per bit; limitation: a strobe must stand more than one clock to be seen.
  logic [SYNC_N-1:0] meta_r;
  logic [SYNC_N-1:0] sync_r;
  for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (srst) begin
        meta_r[g] <= 1'b0;
        sync_r[g] <= 1'b0;
      end else begin
        meta_r[g] <= raw_lvl[g];
        sync_r[g] <= meta_r[g];
      end
    end
  end

  // The edge detector resets to the idle level, so leaving reset makes no false start.
  logic strobe_d_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= sync_r[IX_LOC];
    end
  end

  // Named views of the synchronised levels.
  wire logic loc_s = sync_r[IX_LOC];
  wire logic mate_s = sync_r[IX_MATE];
  wire logic upd_s = sync_r[IX_UPD];
  wire logic rd_s = sync_r[IX_RD];
  wire logic mcr_sel_s = sync_r[IX_SEL];

  // Buses are held stable by the strobe, so sampling them on the strobe edge is safe.
  wire logic cyc_start = loc_s && !strobe_d_r;

  // ********************************************************************
  // Comparison
  // ********************************************************************

  // Cycles must overlap in time; a missing mate strobe counts as a mismatch too.
  // Both buses are compared whole; no partial-width compare is offered.
  wire logic addr_diff = local_addr != mate_addr;
  wire logic data_diff = local_data != mate_data;
  wire logic miscompare = cyc_start && (!mate_s || addr_diff || data_diff);

  // Sticky error; a new mismatch in the clear cycle wins over the clear.
  always_ff @(posedge mclk) begin
    if (srst) begin
      mismatch_error <= 1'b0;
      mismatch_pulse <= 1'b0;
    end else begin
      mismatch_pulse <= miscompare;
      if (miscompare) begin
        mismatch_error <= 1'b1;
      end else if (clear_error) begin
        mismatch_error <= 1'b0;
      end
    end
  end

  // The hold register keeps the first faulty cycle; later faults only keep it locked.
  cycle_hold #(
    .W(DATA_W)
  ) u_hold (
    .mclk(mclk),
    .srst(srst),
    .capture(miscompare),
    .release_lock(release_lock),
    .addr_in(local_addr),
    .data_in(local_data),
    .addr_q(hold_addr),
    .data_q(hold_data),
    .locked(hold_locked)
  );

  // ********************************************************************
  // Outgoing match bus
  // ********************************************************************

  match_phase_t phase_r;
  match_phase_t phase_nxt;
  logic [DATA_W-1:0] data_lat_r;

  // Two beats per cycle: the address word, then the latched data word.
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_IDLE: begin
        if (cyc_start) begin
          phase_nxt = PH_ADDR;
        end
      end
      PH_ADDR: begin
        phase_nxt = PH_DATA;
      end
      default: begin
        phase_nxt = cyc_start ? PH_ADDR : PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_r <= PH_IDLE;
      data_lat_r <= DATA_W'(HOLD_RESET);
      match_out <= DATA_W'(HOLD_RESET);
    end else begin
      phase_r <= phase_nxt;
      if (cyc_start) begin
        data_lat_r <= local_data;
      end
      if (phase_nxt == PH_ADDR) begin
        match_out <= local_addr;
      end else if (phase_nxt == PH_DATA) begin
        match_out <= cyc_start ? local_data : data_lat_r;
      end
    end
  end

  // Beat flags come straight from the phase register, so they never glitch.
  // A new cycle may start in the data beat, so back-to-back cycles lose no clock.
  assign match_out_valid = phase_r != PH_IDLE;
  assign match_out_is_data = phase_r == PH_DATA;

  // ********************************************************************
  // Update mode
  // ********************************************************************

  // Mate data is driven only on local reads, so it never fights a local write.
  // The copy lags the incoming bus by one clock; the mate must hold each word that long.
  always_ff @(posedge mclk) begin
    if (srst) begin
      update_data <= DATA_W'(HOLD_RESET);
    end else begin
      update_data <= match_in;
    end
  end

  assign update_data_oe = upd_s && rd_s && loc_s;

  // ********************************************************************
  // Mate communication register
  // ********************************************************************

  // Written from the local data bus; limitation: the write strobe must come from this clock.
  logic [MCR_W-1:0] mcr_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      mcr_r <= MCR_RESET;
      measurement_bus <= MCR_RESET;
    end else begin
      if (mcr_write) begin
        mcr_r <= local_data;
      end
      measurement_bus <= mcr_sel_s ? mcr_r : MCR_RESET;
    end
  end

  // From one clock after deselection the bus shows zeros so the mate never reads a stale word.
  assign measurement_bus_oe = mcr_sel_s;

endmodule // bus_matcher

/* File: verification/bus_matcher_chk.sv */
// Checker for the duplex bus matcher, bound onto every matcher instance.
// Assumes one clock domain and the synchronous reset srst.
module bus_matcher_chk
  import bus_matcher_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clear_error,
  input wire logic release_lock,
  input wire logic [DATA_W-1:0] match_in,
  input wire logic match_out_valid,
  input wire logic match_out_is_data,
  input wire logic [DATA_W-1:0] update_data,
  input wire logic update_data_oe,
  input wire logic [MCR_W-1:0] measurement_bus,
  input wire logic measurement_bus_oe,
  input wire logic mismatch_pulse,
  input wire logic mismatch_error,
  input wire logic hold_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************************************
  // Properties
  // ******************************************************************
  // Reset flushes the syncs, so nothing is judged while it is held.
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_addr_beat;
    match_out_valid && !match_out_is_data;
  endsequence
  sequence s_data_beat;
    match_out_valid && match_out_is_data;
  endsequence
  a_addr_then_data: assert property (s_addr_beat |=> s_data_beat)
    else $error("data beat missing");
  a_pulse_single: assert property (mismatch_pulse |=> !mismatch_pulse)
    else $error("mismatch pulse too long");
  a_pulse_sets_err: assert property (mismatch_pulse |-> mismatch_error)
    else $error("error not set");
  a_err_sticky: assert property (mismatch_error && !clear_error |=> mismatch_error)
    else $error("error dropped");
  a_clear_err: assert property (clear_error ##1 !mismatch_pulse |-> !mismatch_error)
    else $error("error not cleared");
  a_lock_holds: assert property (hold_locked && !release_lock |=> hold_locked)
    else $error("lock dropped");
  a_meas_off: assert property (!measurement_bus_oe [*2] |-> measurement_bus == '0)
    else $error("register seen unselected");
  a_upd_copy: assert property (update_data_oe |-> update_data == $past(match_in))
    else $error("update data wrong");
endmodule // bus_matcher_chk

bind bus_matcher bus_matcher_chk i_chk(.*);

/* File: verification/mate_model.sv */
// Mate card model: presents the mate's copy of each local cycle.
// Assumes the bench changes local cycles off the falling edge.
module mate_model (
  input wire logic mclk,
  input wire logic cycle_strobe,
  input wire logic [31:0] local_addr,
  input wire logic [31:0] local_data,
  input wire logic [31:0] flip,
  output logic mate_strobe,
  output logic [31:0] mate_addr,
  output logic [31:0] mate_data,
  output logic [31:0] match_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************************************
  // Mate bus
  // ******************************************************************
  // Start the incoming match bus from a known nonzero seed.
  initial begin
    match_in = 32'h1;
  end
  // The mate runs in lockstep, so its strobe and copy stand exactly with the local cycle.
  // Between cycles its buses show the inverse, so a stale word never matches.
  assign mate_strobe = cycle_strobe;
  assign mate_addr = cycle_strobe ? local_addr : ~local_addr;
  assign mate_data = cycle_strobe ? local_data ^ flip : ~local_data;
  // The mate's outgoing match bus carries a fresh word every clock.
  always @(posedge mclk) begin
    match_in <= {match_in[30:0], match_in[31] ^ match_in[21]} ^ 32'h5;
  end
endmodule // mate_model

/* File: verification/bus_matcher_tb.sv */
// Testbench for the duplex bus matcher against a mate card model.
// Assumes the checker is bound by its own file.
module bus_matcher_tb import bus_matcher_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, srst = 1, cycle_strobe, cycle_read, mate_strobe, update_req, mcr_write;
  logic mcr_to_measurement_bus, clear_error, release_lock, match_out_valid, match_out_is_data;
  logic update_data_oe, measurement_bus_oe, mismatch_pulse, mismatch_error, hold_locked;
  logic [31:0] local_addr, local_data, mate_addr, mate_data, match_in, flip, match_out;
  logic [31:0] update_data, measurement_bus, hold_addr, hold_data, mi_prev, eha, ehd, ed;
  int errors, cmp_count;
  bit elock, eerr;
  bus_matcher i_bus_matcher(.*);
  mate_model i_mate_model(.*);
  // ******************************************************************
  // Clock, watchdog and tasks
  // ******************************************************************
  // Clock at 40 MHz; the update copy lags match_in by one clock.
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) mi_prev <= match_in;
  // The whole run is under a hundred cycles, so this leaves wide margin.
  initial begin
    #50us;
    errors++;
    results;
  end
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic results;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One local cycle; a nonzero flip makes the mate's data differ.
  task automatic cyc(bit rd, logic [31:0] f);
    int n;
    @(negedge mclk);
    local_addr = $urandom;
    local_data = $urandom;
    cycle_read = rd;
    flip = f;
    cycle_strobe = 1;
    for (n = 0; n < 20 && match_out_valid !== 1; n++) @(negedge mclk);
    if (f != 0 && !elock) begin
      eha = local_addr;
      ehd = local_data;
    end
    elock |= (f != 0);
    eerr |= (f != 0);
    chk("valid", match_out_valid, 1);
    chk("pulse", mismatch_pulse, f != 0);
    chk("addr", match_out, local_addr);
    chk("upd_oe", update_data_oe, rd & update_req);
    if (rd & update_req) chk("upd", update_data, mi_prev);
    @(negedge mclk);
    cycle_strobe = 0;
    chk("is_data", match_out_is_data, 1);
    chk("data", match_out, local_data);
    chk("err", mismatch_error, eerr);
    chk("lock", hold_locked, elock);
    if (elock) chk("hold", hold_addr, eha);
    if (elock) chk("hold_d", hold_data, ehd);
    @(negedge mclk);
    chk("idle", match_out_valid, 0);
    @(negedge mclk);
  endtask
  // ******************************************************************
  // Main sequence
  // ******************************************************************
  // Inputs change on the falling edge only, clear of the sampling edge.
  initial begin
    {cycle_strobe, cycle_read, update_req, mcr_write} = '0;
    {mcr_to_measurement_bus, clear_error, release_lock} = '0;
    {local_addr, local_data, flip, eha, ehd} = '0;
    void'($urandom(45));
    repeat (8) @(negedge mclk);
    srst = 0;
    chk("err0", mismatch_error, 0);
    chk("lock0", hold_locked, 0);
    repeat (3) @(negedge mclk);
    repeat (4) cyc(0, 0);
    cyc(0, 32'h1);
    cyc(1, 32'h8000_0000);
    cyc(0, 0);
    clear_error = 1;
    release_lock = 1;
    @(negedge mclk);
    {clear_error, release_lock, eerr, elock} = '0;
    @(negedge mclk);
    chk("clr", {mismatch_error, hold_locked}, 0);
    local_data = $urandom;
    ed = local_data;
    mcr_write = 1;
    @(negedge mclk);
    mcr_write = 0;
    mcr_to_measurement_bus = 1;
    repeat (4) @(negedge mclk);
    chk("mb", measurement_bus, ed);
    chk("mb_oe", measurement_bus_oe, 1);
    mcr_to_measurement_bus = 0;
    repeat (4) @(negedge mclk);
    chk("mb_off", measurement_bus, 0);
    chk("mb_oe_off", measurement_bus_oe, 0);
    update_req = 1;
    repeat (3) @(negedge mclk);
    cyc(1, 0);
    cyc(0, 0);
    results;
  end
endmodule // bus_matcher_tb
